// >>> src/mmd_decoder.sv
// Registered memory map decoder with stack pointer tracking.
`timescale 1ns/1ps
`include "mmd_defs.svh"
module mmd_decoder #(
  parameter int ADDR_W = 13
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [ADDR_W-1:0] cpu_addr,
  input wire logic cpu_rd,
  input wire logic cpu_wr,
  input wire logic sp_push,
  input wire logic sp_pop,
  input wire logic sp_load,
  output logic io_sel_r,
  output logic ram_sel_r,
  output logic user_rom_sel_r,
  output logic user_vec_sel_r,
  output logic self_rom_sel_r,
  output logic stack_hit_r,
  output logic illegal_addr_r,
  output logic [ADDR_W-1:0] sp_addr
);
  localparam int WIN_N = 6;
  localparam int WIN_IO = 0;
  localparam int WIN_RAM = 1;
  localparam int WIN_UROM = 2;
  localparam int WIN_UVEC = 3;
  localparam int WIN_SELF = 4;
  localparam int WIN_STK = 5;

  mmd_pkg::mmd_region_t region;
  logic access;
  logic [WIN_N-1:0] win_hit;
  logic [5:0] sp_low_r;
  logic [5:0] sp_low_nxt;

  // A wider bus would alias every window into the holes, so it is refused when built.
  if (ADDR_W != `MMD_ADDR_W) begin : g_bad_width
    $error("mmd_decoder: only the 13-bit, 8 Kbyte map is supported");
  end

  function automatic logic in_range(input logic [12:0] a, input logic [12:0] lo,
                                    input logic [12:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  // An unknown index gives an empty window, so it can never select anything.
  function automatic logic [12:0] win_lo(input int idx);
    case (idx)
      WIN_IO: win_lo = `MMD_IO_LO;
      WIN_RAM: win_lo = `MMD_RAM_LO;
      WIN_UROM: win_lo = `MMD_UROM_LO;
      WIN_UVEC: win_lo = `MMD_UVEC_LO;
      WIN_SELF: win_lo = `MMD_SCROM_LO;
      WIN_STK: win_lo = `MMD_STK_LO;
      default: win_lo = 13'h1fff;
    endcase
  endfunction

  function automatic logic [12:0] win_hi(input int idx);
    case (idx)
      WIN_IO: win_hi = `MMD_IO_HI;
      WIN_RAM: win_hi = `MMD_RAM_HI;
      WIN_UROM: win_hi = `MMD_UROM_HI;
      WIN_UVEC: win_hi = `MMD_UVEC_HI;
      WIN_SELF: win_hi = `MMD_SCROM_HI;
      WIN_STK: win_hi = `MMD_STK_HI;
      default: win_hi = 13'h0000;
    endcase
  endfunction

  assign access = cpu_rd | cpu_wr;

  // The full 13-bit address is compared in every window, so there are no aliases.
  for (genvar g = 0; g < WIN_N; g++) begin : g_win
    assign win_hit[g] = in_range(cpu_addr, win_lo(g), win_hi(g));
  end

  always_comb begin
    if (win_hit[WIN_IO]) begin
      region = mmd_pkg::MMD_REG_IO;
    end else if (win_hit[WIN_RAM]) begin
      region = mmd_pkg::MMD_RAM;
    end else if (win_hit[WIN_UROM] || win_hit[WIN_UVEC]) begin
      region = mmd_pkg::MMD_USER_ROM;
    end else if (win_hit[WIN_SELF]) begin
      region = mmd_pkg::MMD_SELF_ROM;
    end else begin
      region = mmd_pkg::MMD_NONE;
    end
  end

  // Selects are registered so the memories see glitch-free enables one cycle on.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      io_sel_r <= 1'b0;
    end else begin
      io_sel_r <= access && region == mmd_pkg::MMD_REG_IO;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ram_sel_r <= 1'b0;
    end else begin
      ram_sel_r <= access && region == mmd_pkg::MMD_RAM;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      user_rom_sel_r <= 1'b0;
    end else begin
      user_rom_sel_r <= access && region == mmd_pkg::MMD_USER_ROM;
    end
  end

  // The vector flag rides on top of the user ROM select rather than replacing it.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      user_vec_sel_r <= 1'b0;
    end else begin
      user_vec_sel_r <= access && win_hit[WIN_UVEC];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      self_rom_sel_r <= 1'b0;
    end else begin
      self_rom_sel_r <= access && region == mmd_pkg::MMD_SELF_ROM;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      stack_hit_r <= 1'b0;
    end else begin
      stack_hit_r <= access && win_hit[WIN_STK];
    end
  end

  // One-cycle pulse per access that lands in a hole of the map.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      illegal_addr_r <= 1'b0;
    end else begin
      illegal_addr_r <= access && region == mmd_pkg::MMD_NONE;
    end
  end

  // Only the low six bits move, so wrap-around stays inside the window
  // instead of spilling into data RAM; software must avoid deep nesting.
  always_comb begin
    sp_low_nxt = sp_low_r;
    if (sp_load) begin
      sp_low_nxt = 6'(`MMD_SP_RESET);
    end else if (sp_push && !sp_pop) begin
      sp_low_nxt = sp_low_r - 6'h01;
    end else if (sp_pop && !sp_push) begin
      sp_low_nxt = sp_low_r + 6'h01;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      sp_low_r <= 6'(`MMD_SP_RESET);
    end else begin
      sp_low_r <= sp_low_nxt;
    end
  end

  mmd_stack_clamp #(
    .ADDR_W(ADDR_W)
  ) u_clamp (
    .sp_low(sp_low_r),
    .sp_addr(sp_addr)
  );
endmodule // mmd_decoder

// >>> src/mmd_defs.svh
// Address map constants for the memory map decoder.
`ifndef MMD_DEFS_SVH
`define MMD_DEFS_SVH
`define MMD_ADDR_W 13
`define MMD_IO_LO 13'h0000
`define MMD_IO_HI 13'h001f
`define MMD_RAM_LO 13'h0080
`define MMD_RAM_HI 13'h01ff
`define MMD_STK_LO 13'h00c0
`define MMD_STK_HI 13'h00ff
`define MMD_SP_RESET 13'h00ff
`define MMD_UROM_LO 13'h0b00
`define MMD_UROM_HI 13'h1eff
`define MMD_SCROM_LO 13'h1f00
`define MMD_SCROM_HI 13'h1fef
`define MMD_UVEC_LO 13'h1ff0
`define MMD_UVEC_HI 13'h1fff
`endif

// >>> src/mmd_pkg.sv
// Types shared by the memory map decoder.
package mmd_pkg;
  typedef enum logic [2:0] {
    MMD_REG_IO,
    MMD_RAM,
    MMD_USER_ROM,
    MMD_SELF_ROM,
    MMD_NONE
  } mmd_region_t;
endpackage

// >>> src/mmd_stack_clamp.sv
// Forces a stack pointer offset into the stack window.
`timescale 1ns/1ps
`include "mmd_defs.svh"
module mmd_stack_clamp #(
  parameter int ADDR_W = 13
) (
  input wire logic [5:0] sp_low,
  output logic [ADDR_W-1:0] sp_addr
);
  // The window is fixed in a 13-bit map, so any other width is refused when built.
  if (ADDR_W != `MMD_ADDR_W) begin : g_bad_width
    $error("mmd_stack_clamp: address width must be 13");
  end

  // Upper bits are fixed so no pointer value can leave the window.
  assign sp_addr = `MMD_STK_LO | {7'h00, sp_low};
endmodule // mmd_stack_clamp

// >>> verification/mmd_monitor.sv
// Assertion checker for the memory map decoder.
`timescale 1ns/1ps
module mmd_monitor(input wire logic sys_clk, srst, cpu_rd, cpu_wr, io_sel_r, ram_sel_r,
  user_rom_sel_r, user_vec_sel_r, self_rom_sel_r, illegal_addr_r, stack_hit_r,
  sp_push, sp_pop, sp_load,
  input wire logic [12:0] cpu_addr, sp_addr);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  wire s = cpu_rd | cpu_wr;
  wire [12:0] a = cpu_addr;
  property p_one; s |=> $onehot({io_sel_r, ram_sel_r, user_rom_sel_r, self_rom_sel_r,
    illegal_addr_r}); endproperty
  a_one: assert property (p_one) else $error("region");
  property p_rom; s && a >= 13'h0b00 && a < 13'h1f00 |=> user_rom_sel_r; endproperty
  a_rom: assert property (p_rom) else $error("rom");
  property p_vec; s && a >= 13'h1ff0 |=> user_rom_sel_r && user_vec_sel_r; endproperty
  a_vec: assert property (p_vec) else $error("vec");
  property p_self; s && a >= 13'h1f00 && a < 13'h1ff0 |=> self_rom_sel_r; endproperty
  a_self: assert property (p_self) else $error("self");
  property p_ram; s && a >= 13'h0080 && a < 13'h0200 |=> ram_sel_r; endproperty
  a_ram: assert property (p_ram) else $error("ram");
  property p_top; $past(srst) |-> sp_addr == 13'h00ff; endproperty
  a_top: assert property (p_top) else $error("sp");
  property p_win; sp_addr >= 13'h00c0 && sp_addr <= 13'h00ff; endproperty
  a_win: assert property (p_win) else $error("win");
  property p_io; s && a <= 13'h001f |=> io_sel_r; endproperty
  a_io: assert property (p_io) else $error("io");
  property p_stk; s && a >= 13'h00c0 && a <= 13'h00ff |=> stack_hit_r && ram_sel_r; endproperty
  a_stk: assert property (p_stk) else $error("stack hit");
  property p_load; sp_load |=> sp_addr == 13'h00ff; endproperty
  a_load: assert property (p_load) else $error("sp load");
  property p_push; sp_push && !sp_pop && !sp_load && sp_addr != 13'h00c0
    |=> sp_addr == $past(sp_addr) - 13'h0001; endproperty
  a_push: assert property (p_push) else $error("sp push");
  property p_pop; sp_pop && !sp_push && !sp_load && sp_addr != 13'h00ff
    |=> sp_addr == $past(sp_addr) + 13'h0001; endproperty
  a_pop: assert property (p_pop) else $error("sp pop");
  property p_hold; !sp_push && !sp_pop && !sp_load |=> $stable(sp_addr); endproperty
  a_hold: assert property (p_hold) else $error("sp hold");
  property p_bad; s && ((a > 13'h001f && a < 13'h0080) || (a > 13'h01ff && a < 13'h0b00))
    |=> illegal_addr_r; endproperty
  a_bad: assert property (p_bad) else $error("bad");
  c_vec: cover property (s && a == 13'h1fff);
  c_bad: cover property (s && a == 13'h0aff);
  c_low: cover property (sp_addr == 13'h00c0);
endmodule // mmd_monitor
bind mmd_decoder mmd_monitor mon_u (.*);

// >>> verification/mmd_cpu_model.sv
// CPU core model that drives the decoder address bus.
`timescale 1ns/1ps
module mmd_cpu_model(input wire logic sys_clk, output logic cpu_rd = 1'h0, cpu_wr = 1'h0,
  output logic [12:0] cpu_addr = 13'h0000);
  // A released bus shows the inverted address so stale values never decode by luck.
  task access(logic [12:0] d, logic w);
    @(posedge sys_clk) #1 {cpu_addr, cpu_rd, cpu_wr} = {d, !w, w};
    @(posedge sys_clk) #1 {cpu_addr, cpu_rd, cpu_wr} = {~d, 2'h0};
  endtask
endmodule // mmd_cpu_model

// >>> verification/mmd_decoder_tb.sv
// Self-checking testbench for the memory map decoder.
`timescale 1ns/1ps
module mmd_decoder_tb;
  logic sys_clk = 0, srst = 1, sp_push = 0, sp_pop = 0, sp_load = 0;
  wire cpu_rd, cpu_wr, io_sel_r, ram_sel_r, user_rom_sel_r, user_vec_sel_r, self_rom_sel_r;
  wire stack_hit_r, illegal_addr_r;
  wire [12:0] cpu_addr, sp_addr;
  wire [6:0] sel = {stack_hit_r, io_sel_r, ram_sel_r, user_rom_sel_r, user_vec_sel_r,
    self_rom_sel_r, illegal_addr_r};
  int mismatches = 0, n_tests = 0;
  mmd_cpu_model cpu_u (.*);
  mmd_decoder dut_u (.*);
  initial forever #5 sys_clk = ~sys_clk;
  task chk(string n, logic [12:0] e, g);
    n_tests++;
    mismatches += int'(g !== e);
    if (g !== e) $display("[FAIL] %s expected %h seen %h", n, e, g);
  endtask
  // One pulse per call, with an idle edge after it so no signal is set twice at once.
  task step(logic [2:0] c);
    @(posedge sys_clk) #1 {sp_push, sp_pop, sp_load} = c;
    @(posedge sys_clk) #1 {sp_push, sp_pop, sp_load} = 3'h0;
  endtask
  task t_map;
    logic [12:0] ad[16] = '{13'h0000, 13'h001f, 13'h0020, 13'h007f, 13'h0080, 13'h00c0,
      13'h00ff, 13'h01ff, 13'h0200, 13'h0aff, 13'h0b00, 13'h1eff, 13'h1f00, 13'h1fef,
      13'h1ff0, 13'h1fff};
    logic [6:0] ex[16] = '{7'h20, 7'h20, 7'h01, 7'h01, 7'h10, 7'h50, 7'h50, 7'h10, 7'h01,
      7'h01, 7'h08, 7'h08, 7'h02, 7'h02, 7'h0c, 7'h0c};
    for (int i = 0; i < 16; i++) begin
      cpu_u.access(ad[i], i[0]);
      chk("select", {6'h00, ex[i]}, {6'h00, sel});
    end
    @(posedge sys_clk) #1 chk("idle", 13'h0000, {6'h00, sel});
    $display("map done");
  endtask
  task t_stack;
    chk("sp", 13'h00ff, sp_addr);
    step(3'h6);
    chk("sp", 13'h00ff, sp_addr);
    repeat (63) step(3'h4);
    chk("sp", 13'h00c0, sp_addr);
    step(3'h4);
    chk("sp", 13'h00ff, sp_addr);
    step(3'h2);
    chk("sp", 13'h00c0, sp_addr);
    step(3'h5);
    chk("sp", 13'h00ff, sp_addr);
    $display("stack done");
  endtask
  task t_reset;
    repeat (3) step(3'h4);
    chk("sp", 13'h00fc, sp_addr);
    srst = 1;
    cpu_u.access(13'h0b00, 1'b0);
    chk("select", 13'h0000, {6'h00, sel});
    chk("sp", 13'h00ff, sp_addr);
    srst = 0;
    cpu_u.access(13'h0b00, 1'b0);
    chk("select", 13'h0008, {6'h00, sel});
    $display("reset done");
  endtask
  task test_done(int x);
    mismatches += x;
    $display("%0d checks, %0d mismatches", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge sys_clk);
    #1 srst = 0;
    t_map;
    t_stack;
    t_reset;
    test_done(0);
  end
  initial #10000 test_done(1);
endmodule // mmd_decoder_tb
